/* hw/rps_pkg.sv */
package rps_pkg;

  // ==========================================================================
  // Reset phases
  // ==========================================================================
  typedef enum logic [1:0]
  {
    RPS_IN_RESET,
    RPS_OUT_RESET,
    RPS_PREFETCH,
    RPS_RUN
  } rps_phase_e;

  // ==========================================================================
  // Pin values across reset
  // ==========================================================================
  localparam logic [19:0] RPS_SA_IN_RESET   = 20'hfff00;
  localparam logic [19:0] RPS_SA_OUT_RESET  = 20'hfff03;
  localparam logic [23:0] RPS_BOOT_ADDR     = 24'hfffff0;
  localparam logic [15:0] RPS_DATA_OUT_RST  = 16'h00ff;
  localparam logic [6:0]  RPS_LA_OUT_RESET  = 7'h00;
  localparam logic [2:0]  RPS_DACK_IDLE     = 3'h4;
  localparam logic [2:0]  RPS_IDE_ADDR_RST  = 3'h0;
  localparam logic [15:0] RPS_GPIO_RST      = 16'hffff;
  localparam logic [7:0]  RPS_IOCS_IDLE     = 8'hff;

  // Number of prefetch words issued after the reset output is released.
  localparam int          RPS_PREFETCH_WORDS = 8;
  // Clock cycles per prefetch word.
  localparam logic [3:0]  RPS_CYC_PER_WORD   = 4'h4;

  // ==========================================================================
  // Pin groups
  // ==========================================================================
  typedef struct packed
  {
    logic [19:0] addr;
    logic [6:0]  la;
    logic [15:0] data;
    logic        data_oe;
    logic        memory_write_strobe_b;
    logic        low_memr_b;
    logic        low_memory_write_strobe_b;
    logic        ior_b;
    logic        iow_b;
    logic        refresh_b;
  } rps_isa_s;

  typedef struct packed
  {
    logic [15:0] data;
    logic        data_oe;
    logic        rd_b;
    logic        wr_b;
    logic [7:0]  iocs_b;
  } rps_lb_s;

endpackage

/* hw/rps_prefetch.sv */
`timescale 1ns/1ps
`default_nettype none

// Walks a short run of boot-code reads once the phase reaches prefetch.
module rps_prefetch
  import rps_pkg::*;
#(
  parameter int WORDS = RPS_PREFETCH_WORDS
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Control
  input  wire logic        start_i,
  // Cycle outputs
  output logic             busy_o,
  output logic             strobe_o,
  output logic [23:0]      addr_o,
  output logic             done_o
);

  logic [3:0]  cyc_ff;
  logic [7:0]  word_ff;
  logic        busy_ff;
  logic        done_ff;
  logic [23:0] addr_ff;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cyc_ff  <= 4'h0;
      word_ff <= 8'h00;
      // R4: boot address start
      addr_ff <= RPS_BOOT_ADDR;
    end
    else if (start_i && !busy_ff && !done_ff)
    begin
      busy_ff <= 1'b1;
      cyc_ff  <= 4'h0;
      word_ff <= 8'h00;
      addr_ff <= RPS_BOOT_ADDR;
    end
    else if (busy_ff)
    begin
      if (cyc_ff == RPS_CYC_PER_WORD - 4'h1)
      begin
        cyc_ff  <= 4'h0;
        addr_ff <= addr_ff + 24'h000002;
        if (word_ff == 8'(WORDS - 1))
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        else
        begin
          word_ff <= word_ff + 8'h01;
        end
      end
      else
      begin
        cyc_ff <= cyc_ff + 4'h1;
      end
    end
  end

  // The strobe is high in the middle two cycles so address settles first.
  assign busy_o   = busy_ff;
  assign strobe_o = busy_ff && (cyc_ff == 4'h1 || cyc_ff == 4'h2);
  assign addr_o   = addr_ff;
  assign done_o   = done_ff;

endmodule

`default_nettype wire

/* hw/rps_reset_pins.sv */
// Overview of operation
// R1: ISA/IDE select high during reset, low after reset output release.
// R2: ISA address 0xFFFXX during reset input, 0xFFF03 during output reset.
// R3: After reset output release, prefetch on ISA when in ISA or PCMCIA mode.
// R4: First prefetch starts at boot address 0xFFFFF0.
// R5: ISA data undefined in input reset, 0xFF during output reset.
// R6: Latched upper address undefined in input reset, then 0x00.
// R7: Memory and I/O strobes undefined in input reset, then high.
// R8: Refresh strobe high after reset input release.
// R9: Encoded DMA acknowledge inputs during reset, 0x04 after release.
// R10: GPIO chip select tristate during reset, high after release.
// R11: RTC address strobe low after reset input release.
// R12: Local data 0xFF after reset input, prefetch after output release.
// R13: Local read strobe high, then used for prefetch after release.
// R14: Local write strobe and eight I/O selects stay high through reset.
// R15: IDE device address low after reset input release.
// R16: All four IDE chip selects low after reset input release.
// R17: Both IDE DMA acknowledges high during reset.
// R18: Two-wire serial clock stays an undriven input during reset.
// R19: Board gates each IDE chip select with the ISA/IDE select.
// R20: GPIO high, test data out high, speaker low through reset.
`timescale 1ns/1ps
`default_nettype none

module rps_reset_pins
  import rps_pkg::*;
#(
  parameter int PREFETCH_WORDS = RPS_PREFETCH_WORDS
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Reset phase inputs
  input  wire logic        system_reset_input_b_i,
  input  wire logic        system_reset_output_b_i,
  input  wire logic        isa_boot_mode_i,
  // Functional values once running
  input  wire logic [19:0] run_isa_system_address_i,
  input  wire logic [2:0]  run_encoded_dma_acknowledge_i,
  input  wire logic [15:0] run_gpio_i,
  input  wire logic        run_speaker_drive_i,
  // Phase and prefetch status
  output rps_phase_e       phase_o,
  output logic             prefetch_done_o,
  // ISA pins
  output logic             isa_ide_output_select_o,
  output rps_isa_s         isa_o,
  output logic [2:0]       encoded_dma_acknowledge_o,
  output logic             encoded_dma_acknowledge_oe_o,
  output logic             gpio_chip_select_b_o,
  output logic             gpio_chip_select_oe_o,
  output logic             rtc_address_strobe_o,
  // Local bus pins
  output rps_lb_s          lb_o,
  // IDE pins
  output logic [2:0]       ide_device_address_o,
  output logic             ide_primary_select_a_o,
  output logic             ide_primary_select_b_o,
  output logic             ide_secondary_select_a_o,
  output logic             ide_secondary_select_b_o,
  output logic             ide_primary_dma_ack_b_o,
  output logic             ide_secondary_dma_ack_b_o,
  // Two-wire, GPIO, test and speaker pins
  output logic             serial_clock_o,
  output logic             serial_clock_oe_o,
  output logic [15:0]      gpio_o,
  output logic             test_data_out_o,
  output logic             speaker_drive_o
);

  rps_phase_e  phase_ff;
  rps_phase_e  nxt_phase;
  logic        pf_start;
  logic        pf_busy;
  logic        pf_strobe;
  logic [23:0] pf_addr;
  logic        pf_done;
  logic        isa_pf;
  logic        lb_pf;
  logic        in_reset;
  logic        pf_rst_b;
  logic [3:0]  ide_sel;

  // ==========================================================================
  // Phase decoding
  // ==========================================================================
  // Both reset phases hold the pins at their reset levels and keep the
  // prefetch sequencer cleared, so the test lives in one place.
  function automatic logic is_reset_phase(input rps_phase_e phase);
    logic hit;
    hit = 1'b0;
    if (phase == RPS_IN_RESET)
    begin
      hit = 1'b1;
    end
    else if (phase == RPS_OUT_RESET)
    begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // The acknowledge, GPIO and speaker run values reach the pins only once the boot reads are over.
  function automatic logic is_run_phase(input rps_phase_e phase);
    logic hit;
    hit = 1'b0;
    if (phase == RPS_RUN)
    begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // ==========================================================================
  // Phase tracking
  // ==========================================================================
  // Either reset input dropping overrides the forward order, so a glitch
  // on the board restarts the sequence instead of skipping a phase.
  always_comb
  begin
    nxt_phase = phase_ff;
    case (phase_ff)
      RPS_IN_RESET:
      begin
        if (system_reset_input_b_i)
        begin
          nxt_phase = RPS_OUT_RESET;
        end
      end
      RPS_OUT_RESET:
      begin
        if (system_reset_output_b_i)
        begin
          nxt_phase = RPS_PREFETCH;
        end
      end
      RPS_PREFETCH:
      begin
        if (pf_done)
        begin
          nxt_phase = RPS_RUN;
        end
      end
      RPS_RUN:
      begin
        nxt_phase = RPS_RUN;
      end
      default:
      begin
        nxt_phase = RPS_IN_RESET;
      end
    endcase
    // A fresh reset input always restarts the sequence.
    if (!system_reset_input_b_i)
    begin
      nxt_phase = RPS_IN_RESET;
    end
    else if (!system_reset_output_b_i && phase_ff != RPS_IN_RESET)
    begin
      nxt_phase = RPS_OUT_RESET;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      phase_ff <= RPS_IN_RESET;
    end
    else
    begin
      phase_ff <= nxt_phase;
    end
  end

  assign phase_o  = phase_ff;
  assign in_reset = is_reset_phase(phase_ff);

  // ==========================================================================
  // Boot prefetch
  // ==========================================================================
  // The sequencer starts on the first cycle of the prefetch phase and is
  // held cleared through both reset phases.
  assign pf_start = (phase_ff == RPS_PREFETCH);
  assign pf_rst_b = rst_b_i && !in_reset;

  // The sequencer keeps its done flag until a reset, so a later return to
  // the reset phases restarts it through its own reset.
  rps_prefetch #(
    .WORDS (PREFETCH_WORDS)
  ) i_rps_prefetch (
    .clk_i    (clk_i),
    .rst_b_i  (pf_rst_b),
    .start_i  (pf_start),
    .busy_o   (pf_busy),
    .strobe_o (pf_strobe),
    .addr_o   (pf_addr),
    .done_o   (pf_done)
  );

  // Only one of the two buses carries the boot reads; the mode input picks it.
  // R3: ISA prefetch mode
  assign isa_pf = pf_busy && isa_boot_mode_i;
  assign lb_pf  = pf_busy && !isa_boot_mode_i;
  assign prefetch_done_o = pf_done;

  // ==========================================================================
  // ISA pins
  // ==========================================================================
  // R1: select follows reset
  assign isa_ide_output_select_o = in_reset;

  // The reset levels are decoded from the registered phase only, so the pins
  // cannot glitch while the reset inputs move between clock edges.
  always_comb
  begin
    isa_o = '0;
    case (phase_ff)
      RPS_IN_RESET:
      begin
        // R2: address during input reset; low byte is don't-care
        isa_o.addr       = RPS_SA_IN_RESET;
        // R5: data undefined, left undriven
        isa_o.data_oe    = 1'b0;
        // R6: upper address undefined
        isa_o.la         = RPS_LA_OUT_RESET;
        // R7: strobes undefined, held inactive
        isa_o.memory_write_strobe_b     = 1'b1;
        isa_o.low_memr_b = 1'b1;
        isa_o.low_memory_write_strobe_b = 1'b1;
        isa_o.ior_b      = 1'b1;
        isa_o.iow_b      = 1'b1;
        isa_o.refresh_b  = 1'b1;
      end
      RPS_OUT_RESET:
      begin
        // R2: address during output reset
        isa_o.addr       = RPS_SA_OUT_RESET;
        // R5: data 0xFF
        isa_o.data       = RPS_DATA_OUT_RST;
        isa_o.data_oe    = 1'b1;
        // R6: upper address zero
        isa_o.la         = RPS_LA_OUT_RESET;
        // R7: strobes inactive
        isa_o.memory_write_strobe_b     = 1'b1;
        isa_o.low_memr_b = 1'b1;
        isa_o.low_memory_write_strobe_b = 1'b1;
        isa_o.ior_b      = 1'b1;
        isa_o.iow_b      = 1'b1;
        // R8: refresh high
        isa_o.refresh_b  = 1'b1;
      end
      default:
      begin
        isa_o.memory_write_strobe_b     = 1'b1;
        isa_o.low_memory_write_strobe_b = 1'b1;
        isa_o.ior_b      = 1'b1;
        isa_o.iow_b      = 1'b1;
        isa_o.refresh_b  = 1'b1;
        if (isa_pf)
        begin
          // R4: ISA prefetch address
          isa_o.addr       = pf_addr[19:0];
          isa_o.la         = pf_addr[23:17];
          isa_o.low_memr_b = !pf_strobe;
        end
        else
        begin
          isa_o.addr       = run_isa_system_address_i;
          isa_o.low_memr_b = 1'b1;
        end
      end
    endcase
  end

  // Limitation: in the run phase the acknowledge code passes straight
  // through; its timing belongs to the DMA logic that supplies it.
  // R9: DMA acknowledge input then idle
  assign encoded_dma_acknowledge_o    = is_run_phase(phase_ff) ? run_encoded_dma_acknowledge_i : RPS_DACK_IDLE;
  assign encoded_dma_acknowledge_oe_o = !in_reset;
  // R10: chip select tristate then high
  assign gpio_chip_select_b_o  = 1'b1;
  assign gpio_chip_select_oe_o = !in_reset;
  // R11: RTC strobe low
  assign rtc_address_strobe_o  = 1'b0;

  // ==========================================================================
  // Local bus pins
  // ==========================================================================
  always_comb
  begin
    lb_o        = '0;
    // R14: writes and selects inactive
    lb_o.wr_b   = 1'b1;
    lb_o.iocs_b = RPS_IOCS_IDLE;
    // R12: local data 0xFF
    lb_o.data    = RPS_DATA_OUT_RST;
    // A local-bus prefetch turns the data lines round to receive boot code,
    // so their enable drops while the sequencer owns the bus.
    lb_o.data_oe = (phase_ff != RPS_IN_RESET) && !lb_pf;
    // R13: read strobe for prefetch
    lb_o.rd_b    = !(lb_pf && pf_strobe);
  end

  // ==========================================================================
  // IDE pins
  // ==========================================================================
  // R15: device address low
  assign ide_device_address_o     = RPS_IDE_ADDR_RST;
  // The selects share pins with the upper ISA address, so the board gates
  // them with the ISA/IDE select before they reach a drive.
  // R16: IDE selects low
  for (genvar gi = 0; gi < 4; gi++)
  begin : g_ide_sel
    assign ide_sel[gi] = 1'b0;
  end
  assign ide_primary_select_a_o   = ide_sel[0];
  assign ide_primary_select_b_o   = ide_sel[1];
  assign ide_secondary_select_a_o = ide_sel[2];
  assign ide_secondary_select_b_o = ide_sel[3];
  // R17: IDE acknowledges high
  assign ide_primary_dma_ack_b_o   = 1'b1;
  assign ide_secondary_dma_ack_b_o = 1'b1;

  // ==========================================================================
  // Miscellaneous pins
  // ==========================================================================
  // The two-wire clock is open-drain with a pull-up, so leaving the enable
  // low lets the line float high; the driven value stays low.
  // R18: serial clock undriven
  assign serial_clock_o    = 1'b0;
  assign serial_clock_oe_o = 1'b0;
  // The run values are not registered here; their source owns their timing.
  // R20: reset levels of GPIO, test and speaker
  assign gpio_o          = is_run_phase(phase_ff) ? run_gpio_i : RPS_GPIO_RST;
  assign test_data_out_o = 1'b1;
  assign speaker_drive_o = is_run_phase(phase_ff) ? run_speaker_drive_i : 1'b0;

endmodule

`default_nettype wire

/* test/rps_board_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Board glue in front of the drives: the select lines are only meaningful in IDE mode.
module rps_board_model
(
  // From the device
  input  wire logic       isa_ide_output_select_i,
  input  wire logic [3:0] ide_select_i,
  // To the drives
  output logic [3:0]      ide_select_gated_o
);
  assign ide_select_gated_o = ide_select_i & {4{isa_ide_output_select_i}};
endmodule

`default_nettype wire

/* test/rps_reset_pins_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module rps_reset_pins_monitor
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Watched pins
  input  wire logic        system_reset_input_b_i,
  input  wire logic        system_reset_output_b_i,
  input  wire rps_phase_e  phase_o,
  input  wire logic        isa_ide_output_select_o,
  input  wire rps_isa_s    isa_o,
  input  wire rps_lb_s     lb_o,
  input  wire logic [2:0]  encoded_dma_acknowledge_o,
  input  wire logic        encoded_dma_acknowledge_oe_o,
  input  wire logic        gpio_chip_select_b_o,
  input  wire logic        gpio_chip_select_oe_o,
  input  wire logic        ide_primary_dma_ack_b_o,
  input  wire logic        ide_secondary_dma_ack_b_o,
  input  wire logic        serial_clock_oe_o,
  input  wire logic [15:0] gpio_o,
  input  wire logic        test_data_out_o,
  input  wire logic        speaker_drive_o
);
  // ==========================================================================
  // Reset phase checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_sel_high;
    !system_reset_output_b_i |=> isa_ide_output_select_o;
  endproperty
  a_sel_high: assert property (p_sel_high) else $error("select not high in reset");
  property p_sel_low;
    $rose(phase_o == RPS_PREFETCH) |-> !isa_ide_output_select_o && $past(isa_ide_output_select_o);
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("select not low after release");
  property p_addr_in;
    !system_reset_input_b_i |=> isa_o.addr[19:8] == 12'hfff;
  endproperty
  a_addr_in: assert property (p_addr_in) else $error("address wrong in input reset");
  property p_out_pins;
    system_reset_input_b_i && !system_reset_output_b_i |=> isa_o.addr == 20'hfff03 && isa_o.data == 16'h00ff
      && isa_o.data_oe && isa_o.la == 7'h00 && {isa_o.memory_write_strobe_b, isa_o.low_memr_b, isa_o.low_memory_write_strobe_b} == 3'h7
      && {isa_o.ior_b, isa_o.iow_b, isa_o.refresh_b} == 3'h7;
  endproperty
  a_out_pins: assert property (p_out_pins) else $error("isa pins wrong in output reset");
  property p_tristate;
    phase_o inside {RPS_IN_RESET, RPS_OUT_RESET} |-> !encoded_dma_acknowledge_oe_o && !gpio_chip_select_oe_o;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pin driven in reset");
  property p_released;
    phase_o == RPS_PREFETCH |-> encoded_dma_acknowledge_oe_o && encoded_dma_acknowledge_o == 3'h4
      && gpio_chip_select_oe_o && gpio_chip_select_b_o;
  endproperty
  a_released: assert property (p_released) else $error("idle levels wrong after release");
  property p_static;
    phase_o != RPS_RUN |-> lb_o.wr_b && lb_o.iocs_b == 8'hff && ide_primary_dma_ack_b_o
      && ide_secondary_dma_ack_b_o && !serial_clock_oe_o && gpio_o == 16'hffff && test_data_out_o
      && !speaker_drive_o;
  endproperty
  a_static: assert property (p_static) else $error("static pin wrong in reset");
  property p_lb_out;
    phase_o == RPS_OUT_RESET |-> lb_o.rd_b && lb_o.data == 16'h00ff && lb_o.data_oe;
  endproperty
  a_lb_out: assert property (p_lb_out) else $error("local bus wrong in output reset");
  property p_prefetch_ends;
    $rose(phase_o == RPS_PREFETCH) |-> ##[1:80] phase_o == RPS_RUN;
  endproperty
  a_prefetch_ends: assert property (p_prefetch_ends) else $error("prefetch did not finish");
endmodule

bind rps_reset_pins rps_reset_pins_monitor i_rps_reset_pins_monitor
(
  .clk_i(clk_i), .rst_b_i(rst_b_i), .system_reset_input_b_i(system_reset_input_b_i),
  .system_reset_output_b_i(system_reset_output_b_i), .phase_o(phase_o), .isa_o(isa_o), .lb_o(lb_o),
  .isa_ide_output_select_o(isa_ide_output_select_o), .encoded_dma_acknowledge_o(encoded_dma_acknowledge_o),
  .encoded_dma_acknowledge_oe_o(encoded_dma_acknowledge_oe_o), .gpio_chip_select_b_o(gpio_chip_select_b_o),
  .gpio_chip_select_oe_o(gpio_chip_select_oe_o), .ide_primary_dma_ack_b_o(ide_primary_dma_ack_b_o),
  .ide_secondary_dma_ack_b_o(ide_secondary_dma_ack_b_o), .serial_clock_oe_o(serial_clock_oe_o),
  .gpio_o(gpio_o), .test_data_out_o(test_data_out_o), .speaker_drive_o(speaker_drive_o)
);

`default_nettype wire

/* test/rps_reset_pins_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module rps_reset_pins_bench;
  import rps_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sri_b = 1'b0;
  logic sro_b = 1'b0;
  logic boot_isa = 1'b1;
  logic [19:0] run_addr = 20'h12345;
  logic [2:0] run_dack = 3'h1;
  logic [15:0] run_gpio = 16'h1234;
  logic run_spk = 1'b1;
  rps_phase_e phase;
  rps_isa_s isa;
  rps_lb_s lb;
  logic done, sel, dack_oe, gcs_b, gcs_oe, rtc, pa, pb, sa, sb, pack_b, sack_b, scl, scl_oe, tdo, spk;
  logic [2:0] dack, ide_addr;
  logic [15:0] gpio;
  logic [3:0] gated;
  int err_total = 0;
  int checks = 0;

  always #20 clk_i = ~clk_i;

  rps_reset_pins i_rps_reset_pins
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .system_reset_input_b_i(sri_b), .system_reset_output_b_i(sro_b),
    .isa_boot_mode_i(boot_isa), .run_isa_system_address_i(run_addr), .run_encoded_dma_acknowledge_i(run_dack),
    .run_gpio_i(run_gpio), .run_speaker_drive_i(run_spk), .phase_o(phase), .prefetch_done_o(done),
    .isa_ide_output_select_o(sel), .isa_o(isa), .encoded_dma_acknowledge_o(dack),
    .encoded_dma_acknowledge_oe_o(dack_oe), .gpio_chip_select_b_o(gcs_b), .gpio_chip_select_oe_o(gcs_oe),
    .rtc_address_strobe_o(rtc), .lb_o(lb), .ide_device_address_o(ide_addr), .ide_primary_select_a_o(pa),
    .ide_primary_select_b_o(pb), .ide_secondary_select_a_o(sa), .ide_secondary_select_b_o(sb),
    .ide_primary_dma_ack_b_o(pack_b), .ide_secondary_dma_ack_b_o(sack_b), .serial_clock_o(scl),
    .serial_clock_oe_o(scl_oe), .gpio_o(gpio), .test_data_out_o(tdo), .speaker_drive_o(spk)
  );

  rps_board_model i_rps_board_model
  (
    .isa_ide_output_select_i(sel),
    .ide_select_i({pa, pb, sa, sb}),
    .ide_select_gated_o(gated)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic set_phase(input logic in_b, input logic out_b);
    @(posedge clk_i);
    sri_b <= in_b;
    sro_b <= out_b;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_in_reset();
    set_phase(1'b0, 1'b0);
    check("phase", phase, RPS_IN_RESET);
    check("select", sel, 1'b1);
    check("addr hi", isa.addr[19:8], 12'hfff);
    check("dack oe", dack_oe, 1'b0);
    check("gpio cs oe", gcs_oe, 1'b0);
    check("lb wr iocs", {lb.wr_b, lb.iocs_b}, 9'h1ff);
    check("ide acks", {pack_b, sack_b}, 2'h3);
    check("scl", {scl_oe, scl}, 2'h0);
    check("gpio tdo spk", {gpio, tdo, spk}, 18'h3fffe);
    $display("test in_reset done");
  endtask

  task automatic t_out_reset();
    set_phase(1'b1, 1'b0);
    check("phase", phase, RPS_OUT_RESET);
    check("addr", isa.addr, 20'hfff03);
    check("isa data", {isa.data_oe, isa.data}, 17'h100ff);
    check("la", isa.la, 7'h00);
    check("strobes", {isa.memory_write_strobe_b, isa.low_memr_b, isa.low_memory_write_strobe_b, isa.ior_b, isa.iow_b}, 5'h1f);
    check("refresh", isa.refresh_b, 1'b1);
    check("rtc", rtc, 1'b0);
    check("lb data", {lb.data_oe, lb.data}, 17'h100ff);
    check("lb rd", lb.rd_b, 1'b1);
    check("ide addr", ide_addr, 3'h0);
    check("ide sel", {pa, pb, sa, sb}, 4'h0);
    check("gated sel", gated, 4'h0);
    $display("test out_reset done");
  endtask

  task automatic t_prefetch(input logic isa_mode);
    int rd_low;
    int isa_low;
    int n;
    logic [26:0] first;
    rd_low = 0;
    isa_low = 0;
    first = 27'h0;
    @(posedge clk_i);
    boot_isa <= isa_mode;
    set_phase(1'b1, 1'b1);
    check("select", sel, 1'b0);
    check("dack", {dack_oe, dack}, 4'hc);
    check("gpio cs", {gcs_oe, gcs_b}, 2'h3);
    for (n = 0; n < 200 && phase !== RPS_RUN; n++)
    begin
      if (lb.rd_b === 1'b0)
        rd_low++;
      if (isa.low_memr_b === 1'b0)
      begin
        // The first read strobe carries the first prefetch address.
        if (isa_low == 0)
          first = {isa.la, isa.addr};
        isa_low++;
      end
      @(negedge clk_i);
    end
    check("run reached", phase, RPS_RUN);
    check("done", done, 1'b1);
    check("boot addr", first, isa_mode ? {RPS_BOOT_ADDR[23:17], RPS_BOOT_ADDR[19:0]} : 27'h0);
    check("isa rd lows", isa_low, isa_mode ? RPS_PREFETCH_WORDS * 2 : 0);
    check("lb rd lows", rd_low, isa_mode ? 0 : RPS_PREFETCH_WORDS * 2);
    check("run addr", isa.addr, run_addr);
    check("run dack", dack, run_dack);
    check("run gpio spk", {gpio, spk}, {run_gpio, run_spk});
    $display("test prefetch mode %0d done", isa_mode);
  endtask

  task automatic t_mid_reset();
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    check("phase", phase, RPS_IN_RESET);
    check("select", sel, 1'b1);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    $display("test mid_reset done");
  endtask

  initial
  begin
    #(40 * 5000);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_in_reset();
    t_out_reset();
    t_prefetch(1'b1);
    t_in_reset();
    t_out_reset();
    t_prefetch(1'b0);
    t_mid_reset();
    t_in_reset();
    report_and_stop();
  end
endmodule

`default_nettype wire
